// file: core/pwmg_apb_regs.sv
`timescale 1ns/1ps
`include "pwmg_map.svh"

module pwmg_apb_regs #(
	parameter int ADDR_W = 12
) (
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic [15:0]       status,
	output logic      [15:0]       period_q,
	output logic      [15:0]       duty_q,
	output logic      [15:0]       ctrl_q
);

	logic [31:0] prdata_q;
	logic        pready_q;
	logic        pslverr_q;

	wire sel_per  = (paddr == ADDR_W'(`PWMG_OFF_PERIOD));
	wire sel_duty = (paddr == ADDR_W'(`PWMG_OFF_DUTY));
	wire sel_ctrl = (paddr == ADDR_W'(`PWMG_OFF_CTRL));
	wire sel_stat = (paddr == ADDR_W'(`PWMG_OFF_STAT));
	wire hit      = sel_per | sel_duty | sel_ctrl | sel_stat;
	wire setup    = psel & ~penable;
	wire wr_en    = psel & penable & pready_q & pwrite & hit;

	// unimplemented bits are never stored, so they read back as zero
	wire [15:0] per_wr  = {pwdata[15:8], 6'h00, pwdata[1:0]};
	wire [15:0] duty_wr = {pwdata[15:8], 6'h00, pwdata[1:0]};
	wire [15:0] ctrl_wr = {15'h0000, pwdata[`PWMG_ON_BIT]};
	wire [15:0] rd_mux  = sel_per  ? period_q :
	                      sel_duty ? duty_q :
	                      sel_ctrl ? ctrl_q :
	                      sel_stat ? status : 16'h0000;

	assign prdata  = prdata_q;
	assign pready  = pready_q;
	assign pslverr = pslverr_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end else begin
			pready_q  <= setup;
			pslverr_q <= setup & ~hit;
			if (setup & ~pwrite) begin
				prdata_q <= {16'h0000, rd_mux};
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			period_q <= `PWMG_PERIOD_RST;
			duty_q   <= `PWMG_DUTY_RST;
			ctrl_q   <= `PWMG_CTRL_RST;
		end else if (wr_en) begin
			if (sel_per) period_q <= per_wr;
			if (sel_duty) duty_q <= duty_wr;
			if (sel_ctrl) ctrl_q <= ctrl_wr;
		end
	end

endmodule

// file: core/pwmg_map.svh
`ifndef PWMG_MAP_SVH
`define PWMG_MAP_SVH

// register byte offsets on the apb bus
`define PWMG_OFF_PERIOD 12'h000
`define PWMG_OFF_DUTY   12'h004
`define PWMG_OFF_CTRL   12'h008
`define PWMG_OFF_STAT   12'h00C

// reset values
`define PWMG_PERIOD_RST 16'h3F00
`define PWMG_DUTY_RST   16'h2000
`define PWMG_CTRL_RST   16'h0000

// field positions
`define PWMG_PER_MSB    15
`define PWMG_PER_LSB    8
`define PWMG_PRE_MSB    1
`define PWMG_PRE_LSB    0
`define PWMG_DHI_MSB    15
`define PWMG_DHI_LSB    8
`define PWMG_DLO_MSB    1
`define PWMG_DLO_LSB    0
`define PWMG_ON_BIT     0

// timing: system clock and fixed timer base, in mhz
`define PWMG_CLK_MHZ    50
`define PWMG_TIMER_MHZ  16
// the count advances in half timer periods
`define PWMG_HALF_MHZ   (2 * `PWMG_TIMER_MHZ)
`define PWMG_DIV1       1
`define PWMG_DIV4       4
`define PWMG_DIV16      16

`endif

// file: core/pwmg_pkg.sv
package pwmg_pkg;

	typedef enum logic [1:0] {
		PWMG_PRE_DIV1,
		PWMG_PRE_DIV4,
		PWMG_PRE_DIV16,
		PWMG_PRE_UNUSED
	} pwmg_pre_t;

endpackage

// file: core/pwmg_tick_gen.sv
`timescale 1ns/1ps
`include "pwmg_map.svh"

module pwmg_tick_gen (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             run,
	input  pwmg_pkg::pwmg_pre_t   pre,
	output logic                  half_tick
);

	localparam logic [6:0] STEP = 7'(`PWMG_HALF_MHZ);
	localparam logic [6:0] WRAP = 7'(`PWMG_CLK_MHZ);

	logic [6:0] acc_q;
	logic [6:0] acc_d;
	logic [3:0] pcnt_q;
	logic [3:0] pcnt_d;

	wire  [6:0] acc_sum = acc_q + STEP;
	wire        base    = (acc_sum >= WRAP);
	wire  [3:0] lim     = (pre == pwmg_pkg::PWMG_PRE_DIV4)  ? 4'(`PWMG_DIV4 - 1) :
	                      (pre == pwmg_pkg::PWMG_PRE_DIV16) ? 4'(`PWMG_DIV16 - 1) :
	                      4'(`PWMG_DIV1 - 1);
	wire        pdone   = (pcnt_q >= lim);

	// fractional divider: average rate is exactly twice the timer base
	assign acc_d     = base ? 7'(acc_sum - WRAP) : acc_sum;
	assign pcnt_d    = !run ? 4'h0 : !base ? pcnt_q : pdone ? 4'h0 : 4'(pcnt_q + 4'h1);
	assign half_tick = run & base & pdone;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_q  <= 7'h00;
			pcnt_q <= 4'h0;
		end else begin
			acc_q  <= acc_d;
			pcnt_q <= pcnt_d;
		end
	end

endmodule

// file: core/pwmg_top.sv
// Behaviour
// - the waveform reaches the pin only while the control register holds one, else the pin is off, and off after reset.
// - the timer runs from a fixed sixteen megahertz base whose period is the reciprocal of that rate.
// - the period register keeps the eight-bit period value in bits fifteen to eight.
// - period register bits one and zero pick the prescaler: 00 by one, 01 by four, 10 by sixteen, 11 unused.
// - the output period is the period value plus one, times two timer periods, times the prescale factor.
// - when the timer reaches the period it clears and sets the pin on the next step, unless the duty is zero.
// - the ten-bit duty value has its upper eight bits in bits fifteen to eight and its lowest two in bits one and zero.
// - the high time is the duty value times half a timer period times the prescale factor.
// - duty writes are taken at any time but only applied once the current period has finished.
// - a duty value beyond the period length keeps the pin high for the whole period.
// - unimplemented bits read as zero in the period, duty and control registers.
// - duty resolution is at most ten bits.
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "pwmg_map.svh"

module pwmg_top #(
	parameter int ADDR_W = 12,
	parameter int PER_W  = 8,
	parameter int DUTY_W = 10
) (
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	output logic                   pwm_pin
);

	logic [15:0]       period_reg;
	logic [15:0]       duty_reg;
	logic [15:0]       ctrl_reg;
	logic              half_tick;
	logic [DUTY_W-1:0] cnt_q;
	logic [DUTY_W-1:0] cnt_d;
	logic [DUTY_W-1:0] duty_act_q;
	logic [DUTY_W-1:0] duty_act_d;
	logic              pin_q;
	logic              pin_d;

	// register file
	wire [15:0] status = {cnt_q[DUTY_W-1:2], 7'h00, pin_q};

	pwmg_apb_regs #(
		.ADDR_W (ADDR_W)
	) u_regs (
		.clk      (clk),
		.rst_n    (rst_n),
		.psel     (psel),
		.penable  (penable),
		.pwrite   (pwrite),
		.paddr    (paddr),
		.pwdata   (pwdata),
		.prdata   (prdata),
		.pready   (pready),
		.pslverr  (pslverr),
		.status   (status),
		.period_q (period_reg),
		.duty_q   (duty_reg),
		.ctrl_q   (ctrl_reg)
	);

	// field extraction
	wire                      on_q    = ctrl_reg[`PWMG_ON_BIT];
	wire [PER_W-1:0]          per_val = period_reg[`PWMG_PER_MSB:`PWMG_PER_LSB];
	wire pwmg_pkg::pwmg_pre_t pre_sel =
		pwmg_pkg::pwmg_pre_t'(period_reg[`PWMG_PRE_MSB:`PWMG_PRE_LSB]);
	// ten-bit duty: high byte then the two low bits
	wire [DUTY_W-1:0] duty_sh = {duty_reg[`PWMG_DHI_MSB:`PWMG_DHI_LSB],
	                             duty_reg[`PWMG_DLO_MSB:`PWMG_DLO_LSB]};

	// half-timer-period steps, prescaled
	pwmg_tick_gen u_tick (
		.clk       (clk),
		.rst_n     (rst_n),
		.run       (on_q),
		.pre       (pre_sel),
		.half_tick (half_tick)
	);

	// the count runs in half timer periods, so one timer step is two of them
	// and the period in counts is four times (period value plus one)
	wire [DUTY_W-1:0] last  = {per_val, 2'b11};
	wire              wrap  = (cnt_q == last);
	wire              step  = on_q & half_tick;
	wire              reload = !on_q | (step & wrap);

	assign cnt_d = !on_q ? '0 :
	               !step ? cnt_q :
	               wrap  ? '0 :
	               DUTY_W'(cnt_q + 1'b1);

	// shadow copy reaches the compare only at the period boundary, and every cycle while the generator is off
	assign duty_act_d = reload ? duty_sh : duty_act_q;

	// high while the count is below the duty: zero duty never sets the pin,
	// a duty past the period end never clears it
	assign pin_d = on_q & (cnt_d < duty_act_d);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q      <= '0;
			duty_act_q <= '0;
			pin_q      <= 1'b0;
		end else begin
			cnt_q      <= cnt_d;
			duty_act_q <= duty_act_d;
			pin_q      <= pin_d;
		end
	end

	assign pwm_pin = pin_q;

	// checks
	wire rd_access = psel & penable & pready & ~pwrite;
	// a duty write as it lands, and the ten bits that it carries
	wire              duty_wr_hit = psel & penable & pready & pwrite &
	                                (paddr == ADDR_W'(`PWMG_OFF_DUTY));
	wire [DUTY_W-1:0] duty_wr_val = {pwdata[15:8], pwdata[1:0]};
	// undivided rate: a gap between half ticks is never two clocks long
	wire              div1_on     = on_q & (pre_sel == pwmg_pkg::PWMG_PRE_DIV1);

	pin_off_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		!on_q |=> !pwm_pin
	) else $error("pin driven while generator off");

	timer_held_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		!on_q |=> (cnt_q == '0) && (duty_act_q == $past(duty_sh))
	) else $error("timer not held at zero while off");

	count_step_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		(on_q && half_tick && !wrap) |=>
			(cnt_q == DUTY_W'($past(cnt_q) + 1'b1))
	) else $error("count did not advance by one");

	count_hold_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		(on_q && !half_tick) |=> $stable(cnt_q)
	) else $error("count moved without a tick");

	period_wrap_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		(on_q && half_tick && wrap && duty_sh != '0 && ctrl_reg[0]) |=>
			(cnt_q == '0) && (on_q -> pwm_pin)
	) else $error("period end did not restart with pin set");

	duty_buffer_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		(on_q && !(half_tick && wrap)) |=> $stable(duty_act_q)
	) else $error("duty applied in mid period");

	high_time_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		on_q |=> (pwm_pin == ($past(on_q) && on_q ? (cnt_q < duty_act_q) : pwm_pin))
	) else $error("pin disagrees with count and duty");

	full_high_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		(on_q && duty_act_q > last) ##1 (on_q && $stable(duty_act_q)) |-> pwm_pin
	) else $error("pin cleared though duty exceeds period");

	zero_duty_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		(duty_act_q == '0) |-> !pwm_pin
	) else $error("pin set at zero duty");

	prescale_gap_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		(half_tick && pre_sel == pwmg_pkg::PWMG_PRE_DIV4) ##1
			(pre_sel == pwmg_pkg::PWMG_PRE_DIV4) [*1] |-> !half_tick
	) else $error("divide-by-four ticks too close");

	reserved_zero_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		(rd_access && !pslverr && paddr != ADDR_W'(`PWMG_OFF_STAT)) |->
			(prdata[7:2] == 6'h00) && (prdata[31:16] == 16'h0000)
	) else $error("unimplemented bits read nonzero");

	ctrl_read_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		(rd_access && paddr == ADDR_W'(`PWMG_OFF_CTRL)) |->
			(prdata[15:1] == 15'h0000)
	) else $error("control upper bits read nonzero");

	duty_width_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		duty_wr_hit |=> (duty_sh == $past(duty_wr_val))
	) else $error("duty not assembled to ten bits");

	// the shadow takes the buffered duty exactly at the boundary
	reload_take_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		(step && wrap) |=> (duty_act_q == $past(duty_sh))
	) else $error("buffered duty not applied at period end");

	// the pin only ever rises at the start of a period
	pin_rise_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		$rose(pwm_pin) |-> (cnt_q == '0)
	) else $error("pin rose away from period start");

	// while the generator stays on, the pin falls exactly when the count meets the duty
	pin_fall_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		($fell(pwm_pin) && on_q && $past(on_q)) |-> (cnt_q == duty_act_q)
	) else $error("pin fell at the wrong count");

	// average rate of twice the timer base leaves no double gap
	tick_rate_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		(div1_on && !half_tick) ##1 div1_on |-> half_tick
	) else $error("half tick missing at undivided rate");

	// no tick at all while the generator is off
	tick_off_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		!on_q |-> !half_tick
	) else $error("timer ticking while off");

	zero_duty_cov: cover property (
		@(posedge clk) disable iff (!rst_n)
		on_q && duty_act_q == '0 && step && wrap
	);

	wrap_cov: cover property (
		@(posedge clk) disable iff (!rst_n)
		on_q && half_tick && wrap ##1 pwm_pin
	);

	duty_apply_cov: cover property (
		@(posedge clk) disable iff (!rst_n)
		on_q && (duty_sh != duty_act_q) ##[1:1000] (half_tick && wrap)
	);

	full_high_cov: cover property (
		@(posedge clk) disable iff (!rst_n)
		on_q && duty_act_q > last && pwm_pin
	);

	enable_cov: cover property (
		@(posedge clk) disable iff (!rst_n)
		!on_q ##1 on_q ##[1:100] pwm_pin
	);

endmodule

// file: tb/pwmg_pin_monitor.sv
`timescale 1ns/1ps

module pwmg_pin_monitor (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        pwm_pin,
	output logic      [15:0] high_cnt,
	output logic      [15:0] per_cnt,
	output logic      [15:0] rises
);
	logic        pin_q;
	logic [15:0] run_q;
	logic [15:0] hi_q;

	// load on the pin: records last high time and rise-to-rise period in clocks
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_q    <= 1'b0;
			run_q    <= 16'h0000;
			hi_q     <= 16'h0000;
			high_cnt <= 16'h0000;
			per_cnt  <= 16'h0000;
			rises    <= 16'h0000;
		end else begin
			pin_q <= pwm_pin;
			if (pwm_pin === 1'b1 && pin_q === 1'b0) begin
				per_cnt <= run_q;
				rises   <= rises + 16'h0001;
				run_q   <= 16'h0001;
				hi_q    <= 16'h0001;
			end else begin
				run_q <= run_q + 16'h0001;
				if (pwm_pin === 1'b1)
					hi_q <= hi_q + 16'h0001;
				if (pwm_pin === 1'b0 && pin_q === 1'b1)
					high_cnt <= hi_q;
			end
		end
	end
endmodule

// file: tb/pwmg_tb.sv
`timescale 1ns/1ps
`include "pwmg_map.svh"

module testbench;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        pwm_pin;
	logic [15:0] high_cnt;
	logic [15:0] per_cnt;
	logic [15:0] rises;
	logic [31:0] rdat;
	logic        serr;
	int          n_mismatch = 0;
	int          checked = 0;

	always #10 clk = ~clk;

	pwmg_top uut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pwm_pin(pwm_pin));
	pwmg_pin_monitor mon (.clk(clk), .rst_n(rst_n), .pwm_pin(pwm_pin), .high_cnt(high_cnt),
		.per_cnt(per_cnt), .rises(rises));

	task automatic finish_test();
		if (n_mismatch == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// pin timing jitters by one clock because the timer base is a fractional divider
	task automatic near(string nm, int exp, logic [15:0] got);
		checked++;
		if ($isunknown(got) || int'(got) > exp + 2 || int'(got) < exp - 2) begin
			n_mismatch++;
			$display("MISMATCH %s expected %0d seen %0d", nm, exp, got);
		end
	endtask

	task automatic xfer(logic w, logic [11:0] a, logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rdat = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk("pready", 1'b1, pready);
	endtask

	task automatic rd_chk(string nm, logic [11:0] a, logic [31:0] exp);
		xfer(1'b0, a, 32'h00000000);
		chk(nm, exp, rdat);
	endtask

	task automatic wait_rises(int k);
		int n;
		int r0;
		n = 0;
		r0 = int'(rises);
		while (int'(rises) - r0 < k && n < 5000) begin
			@(posedge clk);
			n++;
		end
		chk("rise_wait", 1'b1, n < 5000);
	endtask

	// period register fixed at per 3: 16 half ticks per period times prescale
	task automatic measure(int pre, int duty);
		wait_rises(3);
		near("period", 16 * pre * 50 / 32, per_cnt);
		near("high", duty * pre * 50 / 32, high_cnt);
	endtask

	task automatic hold_chk(string nm, logic v);
		logic bad;
		bad = 1'b0;
		repeat (50) begin
			@(posedge clk);
			if (pwm_pin !== v)
				bad = 1'b1;
		end
		chk(nm, 1'b0, bad);
	endtask

	initial begin
		#1_000_000;
		n_mismatch++;
		finish_test();
	end

	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		rd_chk("period_rst", `PWMG_OFF_PERIOD, 32'h00003F00);
		rd_chk("duty_rst", `PWMG_OFF_DUTY, 32'h00002000);
		rd_chk("ctrl_rst", `PWMG_OFF_CTRL, 32'h00000000);
		xfer(1'b1, `PWMG_OFF_PERIOD, 32'hFFFFFFFF);
		rd_chk("period_rsvd", `PWMG_OFF_PERIOD, 32'h0000FF03);
		xfer(1'b1, `PWMG_OFF_DUTY, 32'hFFFFFFFF);
		rd_chk("duty_rsvd", `PWMG_OFF_DUTY, 32'h0000FF03);
		xfer(1'b1, 12'h010, 32'h0000FFFF);
		chk("unmapped_err", 1'b1, serr);
		hold_chk("pin_off", 1'b0);
		xfer(1'b1, `PWMG_OFF_PERIOD, 32'h00000300);
		xfer(1'b1, `PWMG_OFF_DUTY, 32'h00000102);
		xfer(1'b1, `PWMG_OFF_CTRL, 32'h0000FFFF);
		rd_chk("ctrl_rsvd", `PWMG_OFF_CTRL, 32'h00000001);
		measure(1, 6);
		xfer(1'b1, `PWMG_OFF_PERIOD, 32'h00000301);
		measure(4, 6);
		xfer(1'b1, `PWMG_OFF_PERIOD, 32'h00000302);
		measure(16, 6);
		wait_rises(1);
		repeat (10) @(posedge clk);
		xfer(1'b1, `PWMG_OFF_DUTY, 32'h00000300);
		while (pwm_pin === 1'b1) @(posedge clk);
		repeat (2) @(posedge clk);
		near("old_duty_kept", 6 * 16 * 50 / 32, high_cnt);
		measure(16, 12);
		xfer(1'b1, `PWMG_OFF_PERIOD, 32'h00000300);
		xfer(1'b1, `PWMG_OFF_DUTY, 32'h00000000);
		repeat (60) @(posedge clk);
		hold_chk("duty_zero_low", 1'b0);
		xfer(1'b1, `PWMG_OFF_DUTY, 32'h00000500);
		repeat (60) @(posedge clk);
		hold_chk("duty_over_high", 1'b1);
		xfer(1'b1, `PWMG_OFF_CTRL, 32'h00000000);
		repeat (2) @(posedge clk);
		hold_chk("pin_off_again", 1'b0);
		finish_test();
	end
endmodule
